// file: rtl/lnb_supply_pkg.sv
// Constants, carriers and states for the supply regulator control port.
// Functional notes
// - Answer address 0001000 with select pin low, 0001001 with it high.
// - Address byte LSB gives direction: 1 read, 0 write.
// - Written byte MSB 0 loads control register, 1 the thermal register.
// - Control bits 6..1 writable fields; bit 0 read-only overload flag.
// - Thermal register: secondary enable bit 2, overtemp flag bit 1.
// - All bits of both registers are zero at power-on.
// - High level and cable compensation bits encode the output voltage.
// - With output enabled, tone follows gate pin unless tone force is set, then runs always.
// - Threshold bit picks lower current limit at 0, higher at 1.
// - Limit bit picks dynamic protection at 0, static clamp at 1.
// - Output enable at 0 switches converter and regulator off.
// - After read address, shift one register byte out MSB first.
// - Master acknowledge asks another byte; not-acknowledge ends the read.
// - Read-back returns written bits plus live overload and overtemp flags.
// - Flags read 1 while overload or thermal shutdown inputs are active.
// - Supply-good low: ignore bus, no acknowledge, registers held at zero.
// - Output enable rises no earlier than the other configuration bits.
package lnb_supply_pkg;

  localparam logic [6:0] SLAVE_ADDR_LOW  = 7'h08;
  localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h09;
  localparam int         REG_SELECT_BIT  = 7;
  localparam int         FIELD_MSB       = 6;
  localparam int         FIELD_LSB       = 1;
  localparam int         SEC_ENABLE_BIT  = 2;
  localparam logic [2:0] LAST_BIT        = 3'h7;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] THERMAL_RESET   = 8'h00;
  // Pin sync order: ce, overtemp, overload, good, addr, sda, scl.
  localparam logic [6:0] PIN_IDLE        = 7'h03;

  typedef struct packed {
    logic staticLimitSelect;
    logic currentThresholdHigh;
    logic toneForce;
    logic cableDropComp;
    logic highLevelSelect;
    logic outputEnable;
  } supply_ctrl_t;

  localparam supply_ctrl_t CTRL_FIELDS_RESET =
    supply_ctrl_t'(CTRL_RESET[FIELD_MSB:FIELD_LSB]);

  typedef struct packed {
    supply_ctrl_t fields;
    logic         secondaryEnable;
  } wr_cmd_t;

  typedef enum {
    LINK_IDLE,
    LINK_ADDR,
    LINK_ADDR_ACK,
    LINK_WDATA,
    LINK_WDATA_ACK,
    LINK_RDATA,
    LINK_RDATA_ACK
  } link_state_t;

endpackage

// file: rtl/lnb_supply_i2c_control.sv
// Two-wire slave with the supply control and thermal status registers.
`timescale 1ns/1ps
module lnb_supply_i2c_control
  import lnb_supply_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic linkClk,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  input  wire logic addrSelect,
  input  wire logic supplyGood,
  input  wire logic overloadIn,
  input  wire logic overtempIn,
  input  wire logic toneGateInput,
  output logic      converterOff,
  output logic      regulatorOff,
  output logic      outputEnable,
  output logic      highLevelSelect,
  output logic      cableDropComp,
  output logic      toneOn,
  output logic      currentThresholdHigh,
  output logic      staticLimitSelect,
  output logic      secondaryEnable
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rstPipe;
  logic [1:0] linkRstPipe;
  logic       rstSys;
  logic       linkRst;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      linkRstPipe <= 2'h0;
    end else begin
      linkRstPipe <= {linkRstPipe[0], 1'b1};
    end
  end

  assign rstSys  = rstPipe[1];
  assign linkRst = linkRstPipe[1];

  // ==========================================================================
  // Link domain pin synchronisers
  // ==========================================================================
  logic [6:0] pinMeta;
  logic [6:0] pinSync;
  logic       sclS;
  logic       sdaS;
  logic       addrS;
  logic       goodL;
  logic       olfL;
  logic       otfL;
  logic       ceL;

  always_ff @(posedge linkClk or negedge linkRst) begin
    if (!linkRst) begin
      pinMeta <= PIN_IDLE;
      pinSync <= PIN_IDLE;
    end else begin
      pinMeta <= {ce, overtempIn, overloadIn, supplyGood, addrSelect,
                  sdaIn, sclIn};
      pinSync <= pinMeta;
    end
  end

  assign sclS  = pinSync[0];
  assign sdaS  = pinSync[1];
  assign addrS = pinSync[2];
  assign goodL = pinSync[3];
  assign olfL  = pinSync[4];
  assign otfL  = pinSync[5];
  assign ceL   = pinSync[6];

  // ==========================================================================
  // Link protocol engine
  // ==========================================================================
  link_state_t  state;
  logic         sclPrev;
  logic         sdaPrev;
  logic [2:0]   bitCnt;
  logic [7:0]   rxShift;
  logic [7:0]   txShift;
  logic         byteDone;
  logic         rnw;
  logic         readSel;
  logic         ackSeen;
  supply_ctrl_t shadow;
  logic         secShadow;
  wr_cmd_t      wrCmd;
  logic         wrTog;
  logic         startCond;
  logic         stopCond;
  logic         sclRise;
  logic         sclFall;
  logic [6:0]   myAddr;
  logic [7:0]   nextByte;
  wr_cmd_t      next_cmd;

  function automatic logic [7:0] readByte(input logic         sel,
                                          input supply_ctrl_t f,
                                          input logic         sec,
                                          input logic         overload_flag,
                                          input logic         overtemp_flag);
    if (sel) begin
      readByte = {5'h00, sec, overtemp_flag, 1'b0};
    end else begin
      readByte = {1'b0, f, overload_flag};
    end
  endfunction

  assign startCond = sclS && sclPrev && sdaPrev && !sdaS;
  assign stopCond  = sclS && sclPrev && !sdaPrev && sdaS;
  assign sclRise   = sclS && !sclPrev;
  assign sclFall   = !sclS && sclPrev;
  assign myAddr    = addrS ? SLAVE_ADDR_HIGH : SLAVE_ADDR_LOW;
  // Flags are sampled live when each byte is loaded for shifting.
  assign nextByte  = readByte(readSel, shadow, secShadow, olfL, otfL);

  always_comb begin
    next_cmd.fields          = shadow;
    next_cmd.secondaryEnable = secShadow;
    if (rxShift[REG_SELECT_BIT]) begin
      next_cmd.secondaryEnable = rxShift[SEC_ENABLE_BIT];
    end else begin
      next_cmd.fields = supply_ctrl_t'(rxShift[FIELD_MSB:FIELD_LSB]);
    end
  end

  always_ff @(posedge linkClk or negedge linkRst) begin
    if (!linkRst) begin
      state     <= LINK_IDLE;
      sclPrev   <= 1'b1;
      sdaPrev   <= 1'b1;
      bitCnt    <= 3'h0;
      rxShift   <= 8'h00;
      txShift   <= 8'h00;
      byteDone  <= 1'b0;
      rnw       <= 1'b0;
      readSel   <= 1'b0;
      ackSeen   <= 1'b0;
      sdaOe     <= 1'b0;
      shadow    <= CTRL_FIELDS_RESET;
      secShadow <= THERMAL_RESET[SEC_ENABLE_BIT];
      wrCmd     <= '0;
      wrTog     <= 1'b0;
    end else if (ceL) begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
      if (!goodL) begin
        state     <= LINK_IDLE;
        sdaOe     <= 1'b0;
        shadow    <= CTRL_FIELDS_RESET;
        secShadow <= THERMAL_RESET[SEC_ENABLE_BIT];
      end else if (startCond) begin
        state    <= LINK_ADDR;
        bitCnt   <= 3'h0;
        byteDone <= 1'b0;
        readSel  <= 1'b0;
        sdaOe    <= 1'b0;
      end else if (stopCond) begin
        state <= LINK_IDLE;
        sdaOe <= 1'b0;
      end else if (sclRise) begin
        case (state)
          LINK_ADDR, LINK_WDATA: begin
            rxShift  <= {rxShift[6:0], sdaS};
            bitCnt   <= bitCnt + 3'h1;
            byteDone <= (bitCnt == LAST_BIT);
          end
          LINK_RDATA: begin
            bitCnt <= bitCnt + 3'h1;
          end
          LINK_RDATA_ACK: begin
            ackSeen <= !sdaS;
          end
          default: begin
          end
        endcase
      end else if (sclFall) begin
        case (state)
          LINK_ADDR: begin
            if (byteDone) begin
              byteDone <= 1'b0;
              if (rxShift[7:1] == myAddr) begin
                state <= LINK_ADDR_ACK;
                sdaOe <= 1'b1;
                rnw   <= rxShift[0];
              end else begin
                state <= LINK_IDLE;
              end
            end
          end
          LINK_WDATA: begin
            if (byteDone) begin
              byteDone  <= 1'b0;
              state     <= LINK_WDATA_ACK;
              sdaOe     <= 1'b1;
              shadow    <= next_cmd.fields;
              secShadow <= next_cmd.secondaryEnable;
              wrCmd     <= next_cmd;
              wrTog     <= !wrTog;
            end
          end
          LINK_ADDR_ACK, LINK_WDATA_ACK: begin
            if (rnw) begin
              state   <= LINK_RDATA;
              sdaOe   <= !nextByte[7];
              txShift <= {nextByte[6:0], 1'b0};
              readSel <= !readSel;
            end else begin
              state <= LINK_WDATA;
              sdaOe <= 1'b0;
            end
          end
          LINK_RDATA: begin
            if (bitCnt == 3'h0) begin
              state <= LINK_RDATA_ACK;
              sdaOe <= 1'b0;
            end else begin
              sdaOe   <= !txShift[7];
              txShift <= {txShift[6:0], 1'b0};
            end
          end
          LINK_RDATA_ACK: begin
            if (ackSeen) begin
              state   <= LINK_RDATA;
              sdaOe   <= !nextByte[7];
              txShift <= {nextByte[6:0], 1'b0};
              readSel <= !readSel;
            end else begin
              state <= LINK_IDLE;
            end
          end
          default: begin
            state <= LINK_IDLE;
          end
        endcase
      end
    end
  end

  // The pin is open drain: the module only ever pulls it low.
  always_ff @(posedge linkClk or negedge linkRst) begin
    if (!linkRst) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  // ==========================================================================
  // System domain registers and outputs
  // ==========================================================================
  logic [2:0]   sysMeta;
  logic [2:0]   sysSync;
  logic         wrTogPrev;
  logic         goodS;
  logic         toneS;
  logic         wrEvent;
  supply_ctrl_t ctrl;
  logic         secEn;

  always_ff @(posedge clk or negedge rstSys) begin
    if (!rstSys) begin
      sysMeta <= 3'h0;
      sysSync <= 3'h0;
    end else begin
      sysMeta <= {wrTog, toneGateInput, supplyGood};
      sysSync <= sysMeta;
    end
  end

  assign goodS   = sysSync[0];
  assign toneS   = sysSync[1];
  assign wrEvent = sysSync[2] ^ wrTogPrev;

  // The written word stays put for many link cycles after the toggle, so it
  // is stable when the synchronised toggle edge is seen here.
  always_ff @(posedge clk or negedge rstSys) begin
    if (!rstSys) begin
      wrTogPrev <= 1'b0;
      ctrl      <= CTRL_FIELDS_RESET;
      secEn     <= THERMAL_RESET[SEC_ENABLE_BIT];
    end else if (ce) begin
      wrTogPrev <= sysSync[2];
      if (!goodS) begin
        ctrl  <= CTRL_FIELDS_RESET;
        secEn <= THERMAL_RESET[SEC_ENABLE_BIT];
      end else if (wrEvent) begin
        ctrl  <= wrCmd.fields;
        secEn <= wrCmd.secondaryEnable;
      end
    end
  end

  // All outputs load on one edge, so the enable never leads its settings.
  always_ff @(posedge clk or negedge rstSys) begin
    if (!rstSys) begin
      converterOff         <= 1'b1;
      regulatorOff         <= 1'b1;
      outputEnable         <= 1'b0;
      highLevelSelect      <= 1'b0;
      cableDropComp        <= 1'b0;
      toneOn               <= 1'b0;
      currentThresholdHigh <= 1'b0;
      staticLimitSelect    <= 1'b0;
      secondaryEnable      <= 1'b0;
    end else if (ce) begin
      converterOff         <= !(ctrl.outputEnable && goodS);
      regulatorOff         <= !(ctrl.outputEnable && goodS);
      outputEnable         <= ctrl.outputEnable && goodS;
      highLevelSelect      <= ctrl.highLevelSelect;
      cableDropComp        <= ctrl.cableDropComp;
      toneOn               <= ctrl.outputEnable && goodS &&
                              (ctrl.toneForce || toneS);
      currentThresholdHigh <= ctrl.currentThresholdHigh;
      staticLimitSelect    <= ctrl.staticLimitSelect;
      secondaryEnable      <= secEn;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence linkStep;
    ceL && goodL && !startCond && !stopCond && sclFall;
  endsequence

  sequence ackedRead;
    linkStep and (state == LINK_RDATA_ACK && ackSeen);
  endsequence

  sequence nackedRead;
    linkStep and (state == LINK_RDATA_ACK && !ackSeen);
  endsequence

  addr_ack_a: assert property (@(posedge linkClk) disable iff (!linkRst)
    linkStep and (state == LINK_ADDR && byteDone && rxShift[7:1] == myAddr)
    |=> sdaOe && state == LINK_ADDR_ACK)
    else $error("own address not acknowledged");

  foreign_addr_a: assert property (@(posedge linkClk) disable iff (!linkRst)
    linkStep and (state == LINK_ADDR && byteDone && rxShift[7:1] != myAddr)
    |=> !sdaOe && state == LINK_IDLE)
    else $error("foreign address acknowledged");

  read_dir_a: assert property (@(posedge linkClk) disable iff (!linkRst)
    linkStep and (state == LINK_ADDR_ACK && rnw)
    |=> state == LINK_RDATA && sdaOe == !$past(nextByte[7]))
    else $error("read request did not start a byte");

  read_more_a: assert property (@(posedge linkClk) disable iff (!linkRst)
    ackedRead |=> state == LINK_RDATA ##0 readSel != $past(readSel))
    else $error("acknowledged read did not continue");

  read_end_a: assert property (@(posedge linkClk) disable iff (!linkRst)
    nackedRead |=> state == LINK_IDLE && !sdaOe)
    else $error("not-acknowledge did not end read");

  lockout_quiet_a: assert property (@(posedge linkClk) disable iff (!linkRst)
    ceL && !goodL |=> !sdaOe && state == LINK_IDLE && shadow == '0)
    else $error("link active during lockout");

  ctrl_write_a: assert property (@(posedge clk) disable iff (!rstSys)
    ce && goodS && wrEvent
    |=> ctrl == $past(wrCmd.fields) && secEn == $past(wrCmd.secondaryEnable))
    else $error("written command not applied");

  sys_clear_a: assert property (@(posedge clk) disable iff (!rstSys)
    ce && !goodS |=> ctrl == '0 && !secEn ##1 ce |-> !outputEnable)
    else $error("registers not cleared in lockout");

  stages_off_a: assert property (@(posedge clk) disable iff (!rstSys)
    !outputEnable |-> converterOff && regulatorOff)
    else $error("power stage on while disabled");

  enable_last_a: assert property (@(posedge clk) disable iff (!rstSys)
    $rose(outputEnable)
    |-> highLevelSelect == $past(ctrl.highLevelSelect) &&
        cableDropComp == $past(ctrl.cableDropComp))
    else $error("enable rose before its settings");

  tone_force_a: assert property (@(posedge clk) disable iff (!rstSys)
    ce && goodS && ctrl.outputEnable && ctrl.toneForce |=> toneOn)
    else $error("forced tone not running");

endmodule

// file: sim/i2c_master_model.sv
// Behavioural two-wire bus master that talks to the supply regulator port.
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic clk,
  input  wire logic sdaWire,
  output logic      sclPin,
  output logic      sdaDrive
);
  // ==========================================================
  // Bus timing
  // ==========================================================
  // Five system clocks per quarter keeps the SCL high phase of each data bit just above the
  // four link clocks that the slave needs to oversample it.
  localparam int QUARTER = 5;

  initial begin
    sclPin   = 1'b1;
    sdaDrive = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Data only moves while SCL is low and is sampled at the end of high.
  task automatic bitCycle(input logic b, output logic r);
    tick(2);
    sdaDrive = b;
    tick(QUARTER);
    sclPin = 1'b1;
    tick(QUARTER);
    r = sdaWire;
    sclPin = 1'b0;
  endtask

  task automatic startCond();
    tick(2);
    sdaDrive = 1'b1;
    tick(QUARTER);
    sclPin = 1'b1;
    tick(QUARTER);
    sdaDrive = 1'b0;
    tick(QUARTER);
    sclPin = 1'b0;
  endtask

  task automatic stopCond();
    tick(2);
    sdaDrive = 1'b0;
    tick(QUARTER);
    sclPin = 1'b1;
    tick(QUARTER);
    sdaDrive = 1'b1;
    tick(2 * QUARTER);
  endtask

  // The direction bit travels as the last bit of the address byte.
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(d[i], r);
    end
    bitCycle(1'b1, r);
    ack = !r;
  endtask

  task automatic recvByte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, d[i]);
    end
    bitCycle(!ackIt, r);
  endtask
endmodule

// file: sim/lnb_supply_i2c_control_test.sv
// Self-checking bench for the supply regulator two-wire control port.
`timescale 1ns/1ps
module lnb_supply_i2c_control_test;
  logic       clk;
  logic       linkClk;
  logic       rstN;
  logic       addrSelect;
  logic       supplyGood;
  logic       overloadIn;
  logic       overtempIn;
  logic       toneGateInput;
  logic       sdaOut;
  logic       sdaOe;
  logic       converterOff;
  logic       regulatorOff;
  logic       outputEnable;
  logic       highLevelSelect;
  logic       cableDropComp;
  logic       toneOn;
  logic       currentThresholdHigh;
  logic       staticLimitSelect;
  logic       secondaryEnable;
  logic       sclPin;
  logic       sdaDrive;
  logic       sdaWire;
  logic [7:0] outVec;
  logic [7:0] ctrl;
  logic       sec;
  int         failCount;
  int         totalChecks;

  // SDA is open drain with a pull-up: anyone pulling low wins.
  assign sdaWire = sdaDrive & !sdaOe;
  assign outVec  = {staticLimitSelect, currentThresholdHigh, cableDropComp,
                    highLevelSelect, outputEnable, converterOff,
                    regulatorOff, secondaryEnable};

  lnb_supply_i2c_control lnb_supply_i2c_control_i (
    .clk                 (clk),
    .rst_n               (rstN),
    .ce                  (1'b1),
    .linkClk             (linkClk),
    .sclIn               (sclPin),
    .sdaIn               (sdaWire),
    .sdaOut              (sdaOut),
    .sdaOe               (sdaOe),
    .addrSelect          (addrSelect),
    .supplyGood          (supplyGood),
    .overloadIn          (overloadIn),
    .overtempIn          (overtempIn),
    .toneGateInput       (toneGateInput),
    .converterOff        (converterOff),
    .regulatorOff        (regulatorOff),
    .outputEnable        (outputEnable),
    .highLevelSelect     (highLevelSelect),
    .cableDropComp       (cableDropComp),
    .toneOn              (toneOn),
    .currentThresholdHigh(currentThresholdHigh),
    .staticLimitSelect   (staticLimitSelect),
    .secondaryEnable     (secondaryEnable)
  );

  i2c_master_model i2c_master_model_i (
    .clk     (clk),
    .sdaWire (sdaWire),
    .sclPin  (sclPin),
    .sdaDrive(sdaDrive)
  );

  // ==========================================================
  // Clocks and shared tasks
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    linkClk = 1'b0;
    #3;
    forever #6 linkClk = ~linkClk;
  end

  function automatic logic [7:0] expOut(input logic [7:0] c, input logic s);
    return {c[6], c[5], c[3], c[2], c[1], !c[1], !c[1], s};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      failCount++;
    end
  endtask

  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic writeReg(input logic [6:0] a, input logic [7:0] d,
                          output logic [1:0] acks);
    i2c_master_model_i.startCond();
    i2c_master_model_i.sendByte({a, 1'b0}, acks[1]);
    i2c_master_model_i.sendByte(d, acks[0]);
    i2c_master_model_i.stopCond();
    waitClk(6);
  endtask

  // Reads three bytes, the last one not acknowledged, and reports whether
  // the slave let go of SDA afterwards.
  task automatic readRegs(input logic [6:0] a, output logic ack,
                          output logic [7:0] b0, b1, b2, output logic held);
    i2c_master_model_i.startCond();
    i2c_master_model_i.sendByte({a, 1'b1}, ack);
    i2c_master_model_i.recvByte(1'b1, b0);
    i2c_master_model_i.recvByte(1'b1, b1);
    i2c_master_model_i.recvByte(1'b0, b2);
    waitClk(6);
    held = sdaOe;
    i2c_master_model_i.stopCond();
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic testReset();
    logic       ack;
    logic       held;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    chk(outVec, 8'h06);
    chk({7'h00, sdaOut}, 8'h00);
    readRegs(7'h08, ack, b0, b1, b2, held);
    chk({7'h00, ack}, 8'h01);
    chk(b0, 8'h00);
    chk(b1, 8'h00);
    $display("testReset finished");
  endtask

  task automatic testWrite();
    logic [7:0] seq [8] = '{8'h02, 8'h06, 8'h0A, 8'h0E, 8'h60, 8'h7E,
                            8'h84, 8'hFB};
    logic [1:0] acks;
    foreach (seq[i]) begin
      writeReg(7'h08, seq[i], acks);
      if (seq[i][7]) sec = seq[i][2];
      else ctrl = seq[i];
      chk({6'h00, acks}, 8'h03);
      chk(outVec, expOut(ctrl, sec));
    end
    $display("testWrite finished");
  endtask

  task automatic testReadback();
    logic       ack;
    logic       held;
    logic [1:0] acks;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    writeReg(7'h08, 8'h84, acks);
    sec = 1'b1;
    for (int i = 0; i < 2; i++) begin
      overloadIn = (i == 0);
      overtempIn = (i == 1);
      waitClk(6);
      readRegs(7'h08, ack, b0, b1, b2, held);
      chk({7'h00, ack}, 8'h01);
      chk(b0, {1'b0, ctrl[6:1], overloadIn});
      chk(b1, {5'h00, sec, overtempIn, 1'b0});
      chk(b2, {1'b0, ctrl[6:1], overloadIn});
      chk({7'h00, held}, 8'h00);
    end
    overtempIn = 1'b0;
    $display("testReadback finished");
  endtask

  task automatic testTone();
    logic [1:0] acks;
    writeReg(7'h08, 8'h02, acks);
    for (int i = 0; i < 2; i++) begin
      toneGateInput = i[0];
      waitClk(6);
      chk({7'h00, toneOn}, {7'h00, i[0]});
    end
    writeReg(7'h08, 8'h12, acks);
    chk({7'h00, toneOn}, 8'h01);
    toneGateInput = 1'b0;
    waitClk(6);
    chk({7'h00, toneOn}, 8'h01);
    ctrl = 8'h12;
    $display("testTone finished");
  endtask

  task automatic testAddress();
    logic [1:0] acks;
    addrSelect = 1'b1;
    waitClk(6);
    writeReg(7'h08, 8'h0E, acks);
    chk({6'h00, acks}, 8'h00);
    chk(outVec, expOut(ctrl, sec));
    writeReg(7'h09, 8'h0E, acks);
    ctrl = 8'h0E;
    chk({6'h00, acks}, 8'h03);
    chk(outVec, expOut(ctrl, sec));
    addrSelect = 1'b0;
    waitClk(6);
    $display("testAddress finished");
  endtask

  task automatic testLockout();
    logic       ack;
    logic       held;
    logic [1:0] acks;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    supplyGood = 1'b0;
    waitClk(6);
    chk(outVec, 8'h06);
    writeReg(7'h08, 8'h7E, acks);
    chk({6'h00, acks}, 8'h00);
    chk(outVec, 8'h06);
    supplyGood = 1'b1;
    waitClk(6);
    readRegs(7'h08, ack, b0, b1, b2, held);
    chk(b0, 8'h00);
    chk(b1, 8'h00);
    $display("testLockout finished");
  endtask

  // ==========================================================
  // Sequence and verdict
  // ==========================================================
  task automatic completeRun();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    failCount     = 0;
    totalChecks   = 0;
    rstN          = 1'b0;
    addrSelect    = 1'b0;
    supplyGood    = 1'b1;
    overloadIn    = 1'b0;
    overtempIn    = 1'b0;
    toneGateInput = 1'b0;
    ctrl          = 8'h00;
    sec           = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rstN = 1'b1;
    waitClk(10);
    testReset();
    testWrite();
    testReadback();
    testTone();
    testAddress();
    testLockout();
    completeRun();
  end

  // The sequence needs roughly 60 us of bus traffic; five times that is a
  // hang, and the limit still stays well inside the cycle budget.
  initial begin
    #300000;
    failCount++;
    completeRun();
  end
endmodule
